// *** design/mpio_pkg.sv ***
package mpio_pkg;
   // data space byte addresses of the port locations
   localparam logic [7:0] ADDR_L_DATA = 8'hD0;
   localparam logic [7:0] ADDR_L_CFG = 8'hD1;
   localparam logic [7:0] ADDR_L_PIN = 8'hD2;
   localparam logic [7:0] ADDR_G_DATA = 8'hD4;
   localparam logic [7:0] ADDR_G_CFG = 8'hD5;
   localparam logic [7:0] ADDR_G_PIN = 8'hD6;
   localparam logic [7:0] ADDR_M_DATA = 8'h94;
   localparam logic [7:0] ADDR_M_CFG = 8'h95;
   localparam logic [7:0] ADDR_M_PIN = 8'h96;
   localparam logic [7:0] ADDR_N_DATA = 8'hA0;
   localparam logic [7:0] ADDR_N_CFG = 8'hA1;
   localparam logic [7:0] ADDR_N_PIN = 8'hA2;
   localparam logic [7:0] ADDR_N_ALT = 8'hA3;
   localparam logic [7:0] ADDR_D_DATA = 8'hDC;
   localparam logic [7:0] ADDR_I_PIN = 8'hD7;
   localparam logic [7:0] ADDR_M_ALT = 8'h97;
   localparam logic [7:0] ADDR_CAN_CTL = 8'hB0;
   localparam logic [7:0] ADDR_WAKE_EN = 8'hC0;
   localparam logic [7:0] ADDR_WAKE_PEND = 8'hC1;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_D_HIGH = 8'hFF;
   localparam logic [7:0] G_IO_MASK = 8'h3F;
   // special port bit positions
   localparam int G_BIT_IDLE = 6;
   localparam int G_BIT_HALT = 7;
   localparam int G_BIT_ALT_PHASE = 6;
   localparam int G_BIT_CLK_DELAY = 7;
   // alternate function pins of the wakeup port, then can control register bits
   localparam int M_BIT_MISO = 0;
   localparam int M_BIT_MOSI = 1;
   localparam int M_BIT_SCK = 2;
   localparam int M_BIT_SS = 3;
   localparam int M_BIT_CAN = 7;
   localparam int CAN_BIT_CAN_TRANSMIT_DRIVE_ENABLE_0 = 0;
   localparam int CAN_BIT_CAN_TRANSMIT_DRIVE_ENABLE_1 = 1;
   typedef enum logic [1:0] {
      MPIO_RUN = 2'b01,
      MPIO_SLEEP = 2'b10
   } mpio_pwr_t;
endpackage

// *** design/mpio_port.sv ***
`timescale 1ns/1ns
`default_nettype none
module mpio_port
   import mpio_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   input wire logic [W-1:0] l_in,
   output logic [W-1:0] l_out,
   output logic [W-1:0] l_oe,
   output logic [W-1:0] l_pull,
   input wire logic [W-1:0] g_in,
   output logic [W-1:0] g_out,
   output logic [W-1:0] g_oe,
   output logic [W-1:0] g_pull,
   input wire logic [W-1:0] m_in,
   output logic [W-1:0] m_out,
   output logic [W-1:0] m_oe,
   output logic [W-1:0] m_pull,
   input wire logic [W-1:0] n_in,
   output logic [W-1:0] n_out,
   output logic [W-1:0] n_oe,
   output logic [W-1:0] n_pull,
   output logic [W-1:0] d_out,
   input wire logic [W-1:0] i_in,
   input wire logic clock_in,
   output logic clock_output_pin,
   output logic halt_req,
   output logic idle_req,
   output logic serial_shift_clock_alt,
   output logic clock_delay_select,
   input wire logic spi_enable,
   input wire logic spi_master,
   input wire logic spi_miso_o,
   input wire logic spi_mosi_o,
   input wire logic spi_sck_o,
   input wire logic spi_ss_o,
   input wire logic [W-1:0] slave_select_extension,
   input wire logic can_tx_0,
   input wire logic can_tx_1,
   input wire logic can_rx_activity,
   output logic can_transmit_out_0,
   output logic can_transmit_oe_0,
   output logic can_transmit_out_1,
   output logic can_transmit_oe_1,
   output logic multi_input_wakeup
);
   import mpio_pkg::*;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [W-1:0] l_data_reg, l_data_next, l_cfg_reg, l_cfg_next;
   logic [W-1:0] g_data_reg, g_data_next, g_cfg_reg, g_cfg_next;
   logic [W-1:0] m_data_reg, m_data_next, m_cfg_reg, m_cfg_next;
   logic [W-1:0] n_data_reg, n_data_next, n_cfg_reg, n_cfg_next;
   logic [W-1:0] extender_port_alt_enable_reg, n_alt_next;
   logic [W-1:0] m_alt_reg, m_alt_next;
   logic [W-1:0] d_data_reg, d_data_next;
   logic [1:0] can_ctl_reg, can_ctl_next;
   logic [W-1:0] wake_en_reg, wake_en_next;
   logic wake_pend_reg, wake_pend_next;
   logic [W-1:0] l_s1, l_s2, g_s1, g_s2, m_s1, m_s2, n_s1, n_s2;
   logic [W-1:0] i_s1, i_s2;
   logic [W-1:0] l_prev_reg, m_prev_reg;
   logic [7:0] rdata_next;
   mpio_pwr_t pwr_reg, pwr_next;

   function automatic logic wr_at(input logic [7:0] a);
      return bus_wr && (bus_addr == a);
   endfunction

   // next values of software registers
   always_comb begin
      l_data_next = wr_at(ADDR_L_DATA) ? bus_wdata : l_data_reg;
      l_cfg_next = wr_at(ADDR_L_CFG) ? bus_wdata : l_cfg_reg;
      g_data_next = wr_at(ADDR_G_DATA) ? bus_wdata : g_data_reg;
      g_cfg_next = wr_at(ADDR_G_CFG) ? bus_wdata : g_cfg_reg;
      m_data_next = wr_at(ADDR_M_DATA) ? bus_wdata : m_data_reg;
      m_cfg_next = wr_at(ADDR_M_CFG) ? bus_wdata : m_cfg_reg;
      n_data_next = wr_at(ADDR_N_DATA) ? bus_wdata : n_data_reg;
      n_cfg_next = wr_at(ADDR_N_CFG) ? bus_wdata : n_cfg_reg;
      n_alt_next = wr_at(ADDR_N_ALT) ? bus_wdata
                                     : extender_port_alt_enable_reg;
      m_alt_next = wr_at(ADDR_M_ALT) ? bus_wdata : m_alt_reg;
      d_data_next = wr_at(ADDR_D_DATA) ? bus_wdata : d_data_reg;
      can_ctl_next = wr_at(ADDR_CAN_CTL) ? bus_wdata[1:0] : can_ctl_reg;
      wake_en_next = wr_at(ADDR_WAKE_EN) ? bus_wdata : wake_en_reg;
   end

   // registers clear at reset, output port presets high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         l_data_reg <= RST_ZERO;
         l_cfg_reg <= RST_ZERO;
         g_data_reg <= RST_ZERO;
         g_cfg_reg <= RST_ZERO;
         m_data_reg <= RST_ZERO;
         m_cfg_reg <= RST_ZERO;
         n_data_reg <= RST_ZERO;
         n_cfg_reg <= RST_ZERO;
         extender_port_alt_enable_reg <= RST_ZERO;
         m_alt_reg <= RST_ZERO;
         d_data_reg <= RST_D_HIGH;
         can_ctl_reg <= 2'h0;
         wake_en_reg <= RST_ZERO;
      end else begin
         l_data_reg <= l_data_next;
         l_cfg_reg <= l_cfg_next;
         g_data_reg <= g_data_next;
         g_cfg_reg <= g_cfg_next;
         m_data_reg <= m_data_next;
         m_cfg_reg <= m_cfg_next;
         n_data_reg <= n_data_next;
         n_cfg_reg <= n_cfg_next;
         extender_port_alt_enable_reg <= n_alt_next;
         m_alt_reg <= m_alt_next;
         d_data_reg <= d_data_next;
         can_ctl_reg <= can_ctl_next;
         wake_en_reg <= wake_en_next;
      end
   end

   // ---------------------------------------------------------------
   // pin input synchronisers
   // ---------------------------------------------------------------
   // first stage feeds only the second, two cycles of pin latency
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {l_s1, l_s2, g_s1, g_s2} <= {4{RST_ZERO}};
         {m_s1, m_s2, n_s1, n_s2} <= {4{RST_ZERO}};
         {i_s1, i_s2} <= {2{RST_ZERO}};
      end else begin
         l_s1 <= l_in;
         l_s2 <= l_s1;
         g_s1 <= g_in;
         g_s2 <= g_s1;
         m_s1 <= m_in;
         m_s2 <= m_s1;
         n_s1 <= n_in;
         n_s2 <= n_s1;
         i_s1 <= i_in;
         i_s2 <= i_s1;
      end
   end

   // ---------------------------------------------------------------
   // pin drive decode
   // ---------------------------------------------------------------
   logic [W-1:0] m_cfg_eff, m_data_eff, n_data_eff, g_cfg_eff;
   logic [W-1:0] l_out_n, l_oe_n, l_pull_n, g_out_n, g_oe_n, g_pull_n;
   logic [W-1:0] m_out_n, m_oe_n, m_pull_n, n_out_n, n_oe_n, n_pull_n;

   // spi owns its four pins, direction by role
   always_comb begin
      m_cfg_eff = m_cfg_reg;
      m_data_eff = m_data_reg;
      if (spi_enable) begin
         m_cfg_eff[M_BIT_MISO] = !spi_master;
         m_cfg_eff[M_BIT_MOSI] = spi_master;
         m_cfg_eff[M_BIT_SCK] = spi_master;
         m_cfg_eff[M_BIT_SS] = spi_master;
         m_data_eff[M_BIT_MISO] = spi_miso_o;
         m_data_eff[M_BIT_MOSI] = spi_mosi_o;
         m_data_eff[M_BIT_SCK] = spi_sck_o;
         m_data_eff[M_BIT_SS] = spi_ss_o;
      end
      // extender acts as a data write; direction stays software's
      n_data_eff = (n_data_reg & ~extender_port_alt_enable_reg) |
                   (slave_select_extension &
                    extender_port_alt_enable_reg);
      g_cfg_eff = g_cfg_reg & G_IO_MASK;
      // cfg=oe, data=level when driving, data=pullup otherwise
      l_oe_n = l_cfg_reg;
      l_out_n = l_data_reg;
      l_pull_n = ~l_cfg_reg & l_data_reg;
      g_oe_n = g_cfg_eff;
      g_out_n = g_data_reg & G_IO_MASK;
      g_pull_n = ~g_cfg_eff & g_data_reg & G_IO_MASK;
      m_oe_n = m_cfg_eff;
      m_out_n = m_data_eff;
      m_pull_n = ~m_cfg_eff & m_data_eff;
      n_oe_n = n_cfg_reg;
      n_out_n = n_data_eff;
      n_pull_n = ~n_cfg_reg & n_data_eff;
   end

   // output pins straight from flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {l_out, l_oe, l_pull, g_out, g_oe, g_pull} <= {6{RST_ZERO}};
         {m_out, m_oe, m_pull, n_out, n_oe, n_pull} <= {6{RST_ZERO}};
         d_out <= RST_D_HIGH;
         {can_transmit_out_0, can_transmit_oe_0} <= 2'b00;
         {can_transmit_out_1, can_transmit_oe_1} <= 2'b00;
         clock_output_pin <= 1'b0;
      end else begin
         {l_out, l_oe, l_pull} <= {l_out_n, l_oe_n, l_pull_n};
         {g_out, g_oe, g_pull} <= {g_out_n, g_oe_n, g_pull_n};
         {m_out, m_oe, m_pull} <= {m_out_n, m_oe_n, m_pull_n};
         {n_out, n_oe, n_pull} <= {n_out_n, n_oe_n, n_pull_n};
         d_out <= d_data_reg;
         can_transmit_out_0 <= can_tx_0;
         can_transmit_oe_0 <= can_ctl_reg[CAN_BIT_CAN_TRANSMIT_DRIVE_ENABLE_0];
         can_transmit_out_1 <= can_tx_1;
         can_transmit_oe_1 <= can_ctl_reg[CAN_BIT_CAN_TRANSMIT_DRIVE_ENABLE_1];
         clock_output_pin <= clock_in;
      end
   end

   // ---------------------------------------------------------------
   // power modes, special bits and wakeup
   // ---------------------------------------------------------------
   logic [W-1:0] l_edge, m_edge, m_wake_src;
   logic wake_evt;

   // alt-selected m pins drop out; can activity replaces m7
   always_comb begin
      l_edge = (l_s2 ^ l_prev_reg) & wake_en_reg;
      m_wake_src = m_s2;
      m_edge = (m_s2 ^ m_prev_reg) & ~m_alt_reg;
      m_edge[M_BIT_CAN] = m_alt_reg[M_BIT_CAN] ? can_rx_activity
                                               : m_edge[M_BIT_CAN];
      wake_evt = |l_edge || |(m_edge & wake_en_reg);
      // set wins over a software clear in the same cycle
      wake_pend_next = wake_evt ||
                       (wake_pend_reg && !wr_at(ADDR_WAKE_PEND));
      pwr_next = pwr_reg;
      unique case (pwr_reg)
         MPIO_RUN: begin
            if (wr_at(ADDR_G_DATA) &&
                (bus_wdata[G_BIT_HALT] || bus_wdata[G_BIT_IDLE])) begin
               pwr_next = MPIO_SLEEP;
            end
         end
         MPIO_SLEEP: begin
            if (wake_evt) begin
               pwr_next = MPIO_RUN;
            end
         end
      endcase
   end

   // power state, wakeup pending and special strobes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_reg <= MPIO_RUN;
         wake_pend_reg <= 1'b0;
         l_prev_reg <= RST_ZERO;
         m_prev_reg <= RST_ZERO;
         halt_req <= 1'b0;
         idle_req <= 1'b0;
         multi_input_wakeup <= 1'b0;
         serial_shift_clock_alt <= 1'b0;
         clock_delay_select <= 1'b0;
      end else begin
         pwr_reg <= pwr_next;
         wake_pend_reg <= wake_pend_next;
         l_prev_reg <= l_s2;
         m_prev_reg <= m_wake_src;
         // halt and idle hold until a wakeup event or the next special port data write
         halt_req <= wr_at(ADDR_G_DATA) ? bus_wdata[G_BIT_HALT]
                     : (halt_req && !wake_evt);
         idle_req <= wr_at(ADDR_G_DATA) ? bus_wdata[G_BIT_IDLE]
                     : (idle_req && !wake_evt);
         multi_input_wakeup <= wake_pend_next;
         serial_shift_clock_alt <= g_cfg_next[G_BIT_ALT_PHASE];
         clock_delay_select <= g_cfg_next[G_BIT_CLK_DELAY];
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      rdata_next = bus_rdata;
      if (bus_rd) begin
         unique case (bus_addr)
            ADDR_L_DATA: rdata_next = l_data_reg;
            ADDR_L_CFG: rdata_next = l_cfg_reg;
            ADDR_L_PIN: rdata_next = l_s2;
            ADDR_G_DATA: rdata_next = g_data_reg & G_IO_MASK;
            ADDR_G_CFG: rdata_next = g_cfg_reg;
            ADDR_G_PIN: rdata_next = g_s2;
            ADDR_M_DATA: rdata_next = m_data_reg;
            ADDR_M_CFG: rdata_next = m_cfg_reg;
            ADDR_M_PIN: rdata_next = m_s2;
            ADDR_N_DATA: rdata_next = n_data_reg;
            ADDR_N_CFG: rdata_next = n_cfg_reg;
            ADDR_N_PIN: rdata_next = n_s2;
            ADDR_N_ALT: rdata_next = extender_port_alt_enable_reg;
            ADDR_M_ALT: rdata_next = m_alt_reg;
            ADDR_D_DATA: rdata_next = d_data_reg;
            ADDR_I_PIN: rdata_next = i_s2;
            ADDR_CAN_CTL: rdata_next = {6'h00, can_ctl_reg};
            ADDR_WAKE_EN: rdata_next = wake_en_reg;
            ADDR_WAKE_PEND: rdata_next = {7'h00, wake_pend_reg};
            default: rdata_next = RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_rdata <= RST_ZERO;
      end else begin
         bus_rdata <= rdata_next;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_cfg_data_decode;
      @(posedge clk) disable iff (rst)
      ##1 (l_oe == $past(l_cfg_reg)) &&
      (l_pull == ($past(~l_cfg_reg & l_data_reg)));
   endproperty
   a_cfg_data_decode: assert property (p_cfg_data_decode)
      else $error("l port drive decode wrong");

   property p_g_hi_read_zero;
      @(posedge clk) disable iff (rst)
      (bus_rd && bus_addr == ADDR_G_DATA) |=> (bus_rdata[7:6] == 2'b00);
   endproperty
   a_g_hi_read_zero: assert property (p_g_hi_read_zero)
      else $error("special data bits 6,7 not zero");

   property p_halt_write;
      @(posedge clk) disable iff (rst)
      (bus_wr && bus_addr == ADDR_G_DATA && bus_wdata[G_BIT_HALT])
      |=> halt_req;
   endproperty
   a_halt_write: assert property (p_halt_write)
      else $error("halt not requested");

   property p_idle_write;
      @(posedge clk) disable iff (rst)
      (bus_wr && bus_addr == ADDR_G_DATA && bus_wdata[G_BIT_IDLE])
      |=> idle_req ##1 (pwr_reg == MPIO_SLEEP || $past(wake_evt));
   endproperty
   a_idle_write: assert property (p_idle_write)
      else $error("idle not entered");

   property p_alt_phase;
      @(posedge clk) disable iff (rst)
      (bus_wr && bus_addr == ADDR_G_CFG)
      |=> (serial_shift_clock_alt == $past(bus_wdata[G_BIT_ALT_PHASE]));
   endproperty
   a_alt_phase: assert property (p_alt_phase)
      else $error("alternate shift phase not taken");

   property p_spi_master_dir;
      @(posedge clk) disable iff (rst)
      (spi_enable && spi_master) |=> (m_oe[M_BIT_MOSI] && !m_oe[M_BIT_MISO]);
   endproperty
   a_spi_master_dir: assert property (p_spi_master_dir)
      else $error("spi master directions wrong");

   property p_ext_select;
      @(posedge clk) disable iff (rst)
      ##1 ((n_out & $past(extender_port_alt_enable_reg)) ==
           ($past(slave_select_extension) &
            $past(extender_port_alt_enable_reg)));
   endproperty
   a_ext_select: assert property (p_ext_select)
      else $error("extender select not on pin");

   property p_can_oe;
      @(posedge clk) disable iff (rst)
      ##1 (can_transmit_oe_1 == $past(can_ctl_reg[CAN_BIT_CAN_TRANSMIT_DRIVE_ENABLE_1]));
   endproperty
   a_can_oe: assert property (p_can_oe)
      else $error("can drive enable mismatch");

   property p_can_wake;
      @(posedge clk) disable iff (rst)
      (m_alt_reg[M_BIT_CAN] && wake_en_reg[M_BIT_CAN] && can_rx_activity)
      |=> multi_input_wakeup;
   endproperty
   a_can_wake: assert property (p_can_wake)
      else $error("can activity gave no wakeup");

   property p_pin_sync;
      @(posedge clk) disable iff (rst)
      (bus_rd && bus_addr == ADDR_M_PIN) |=> (bus_rdata == $past(m_s2));
   endproperty
   a_pin_sync: assert property (p_pin_sync)
      else $error("pin read wrong");

   c_halt: cover property (@(posedge clk) disable iff (rst)
      halt_req ##[1:20] !halt_req);
   c_spi_slave: cover property (@(posedge clk) disable iff (rst)
      spi_enable && !spi_master);
   c_ext: cover property (@(posedge clk) disable iff (rst)
      |(extender_port_alt_enable_reg & slave_select_extension));
   c_wake: cover property (@(posedge clk) disable iff (rst)
      multi_input_wakeup);
endmodule
`default_nettype wire

// *** verif/mpio_pin_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ------
// external circuitry hanging on one 8-bit port
// ------
module mpio_pin_model #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] pull,
   input wire logic ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] level
);
   // a floating pin wanders, so a stale value never reads as a match
   logic [W-1:0] float_reg = '0;
   always @(posedge clk) begin
      float_reg <= ~float_reg;
   end
   // device drive wins, then the outside driver, then the weak pull-up
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (oe[i])
            level[i] = out[i];
         else if (ext_en)
            level[i] = ext_val[i];
         else if (pull[i])
            level[i] = 1'b1;
         else
            level[i] = float_reg[i];
      end
   end
endmodule
`default_nettype wire

// *** verif/test_multi_port_io_config.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_multi_port_io_config;
   import mpio_pkg::*;
   // ------
   // signals, design and pin models
   // ------
   logic clk, rst, bus_wr, bus_rd, xe, clock_in, clock_output_pin;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, lxv, xv, d_out, i_in;
   logic [7:0] l_in, l_out, l_oe, l_pull, g_in, g_out, g_oe, g_pull;
   logic [7:0] m_in, m_out, m_oe, m_pull, n_in, n_out, n_oe, n_pull;
   logic halt_req, idle_req, serial_shift_clock_alt, clock_delay_select;
   logic spi_enable, spi_master, spi_miso_o, spi_mosi_o, spi_sck_o;
   logic spi_ss_o, can_tx_0, can_tx_1, can_rx_activity;
   logic can_transmit_out_0, can_transmit_oe_0, can_transmit_out_1;
   logic can_transmit_oe_1, multi_input_wakeup;
   logic [7:0] slave_select_extension;
   int error_cnt = 0;
   int n_checks = 0;
   mpio_port dut (.*);
   mpio_pin_model pl (.clk(clk), .oe(l_oe), .out(l_out), .pull(l_pull),
      .ext_en(xe), .ext_val(lxv), .level(l_in));
   mpio_pin_model pg (.clk(clk), .oe(g_oe), .out(g_out), .pull(g_pull),
      .ext_en(xe), .ext_val(xv), .level(g_in));
   mpio_pin_model pm (.clk(clk), .oe(m_oe), .out(m_out), .pull(m_pull),
      .ext_en(xe), .ext_val(xv), .level(m_in));
   mpio_pin_model pn (.clk(clk), .oe(n_oe), .out(n_out), .pull(n_pull),
      .ext_en(xe), .ext_val(xv), .level(n_in));
   // 4 ns clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ------
   // shared tasks
   // ------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // the idle cycle keeps two writes from touching bus_wr in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      cyc(1);
      bus_wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input logic [7:0] k);
      bus_addr = a;
      bus_rd = 1'b1;
      cyc(1);
      bus_rd = 1'b0;
      cyc(1);
      chk(bus_rdata & k, e & k);
   endtask
   task automatic mode_chk(input logic [7:0] oe, input logic [7:0] pu,
                           input logic [7:0] o);
      chk(oe & 8'h3F, 8'h0C);
      chk(pu & 8'h3F, 8'h02);
      chk(o & oe & 8'h3F, 8'h08);
   endtask
   task automatic wake_can();
      can_rx_activity = 1'b1;
      cyc(2);
      can_rx_activity = 1'b0;
      cyc(3);
      chk({6'h00, multi_input_wakeup, halt_req | idle_req}, 8'h02);
      wr(ADDR_WAKE_PEND, 8'hFF);
      cyc(2);
      chk({7'h00, multi_input_wakeup}, 8'h00);
   endtask
   task automatic toggle(input int lport);
      if (lport != 0)
         lxv[0] = ~lxv[0];
      else
         xv[0] = ~xv[0];
      cyc(4);
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_reset();
      cyc(6);
      chk(d_out, 8'hFF);
      cyc(6);
      rst = 1'b0;
      cyc(1);
      chk(l_oe | g_oe | l_pull | g_pull, 8'h00);
      rd(ADDR_L_DATA, 8'h00, 8'hFF);
      rd(ADDR_G_CFG, 8'h00, 8'hFF);
   endtask
   task automatic t_modes();
      logic [7:0] ca[4];
      logic [7:0] da[4];
      ca = '{ADDR_L_CFG, ADDR_G_CFG, ADDR_M_CFG, ADDR_N_CFG};
      da = '{ADDR_L_DATA, ADDR_G_DATA, ADDR_M_DATA, ADDR_N_DATA};
      xe = 1'b1;
      lxv = 8'h5A;
      xv = 8'hA4;
      for (int i = 0; i < 4; i++) begin
         wr(ca[i], 8'h0C);
         wr(da[i], 8'h0A);
      end
      cyc(3);
      mode_chk(l_oe, l_pull, l_out);
      mode_chk(g_oe, g_pull, g_out);
      mode_chk(m_oe, m_pull, m_out);
      mode_chk(n_oe, n_pull, n_out);
      rd(ADDR_M_CFG, 8'h0C, 8'hFF);
      rd(ADDR_N_DATA, 8'h0A, 8'hFF);
      rd(ADDR_L_PIN, (lxv & 8'hF3) | 8'h08, 8'hFF);
      rd(ADDR_M_PIN, (xv & 8'hF3) | 8'h08, 8'hFF);
      rd(ADDR_G_PIN, (xv & 8'hF3) | 8'h08, 8'h3F);
   endtask
   task automatic t_special();
      wr(ADDR_G_CFG, 8'h4C);
      cyc(3);
      chk({6'h00, clock_delay_select, serial_shift_clock_alt}, 8'h01);
      wr(ADDR_G_CFG, 8'h8C);
      cyc(3);
      chk({6'h00, clock_delay_select, serial_shift_clock_alt}, 8'h02);
      rd(ADDR_G_CFG, 8'h8C, 8'hFF);
      clock_in = 1'b1;
      cyc(3);
      chk({7'h00, clock_output_pin}, 8'h01);
      clock_in = 1'b0;
      cyc(3);
      chk({7'h00, clock_output_pin}, 8'h00);
   endtask
   task automatic t_sleep();
      wr(ADDR_WAKE_EN, 8'h80);
      wr(ADDR_M_ALT, 8'h80);
      wr(ADDR_G_DATA, 8'h8A);
      cyc(3);
      chk({6'h00, halt_req, idle_req}, 8'h02);
      rd(ADDR_G_DATA, 8'h0A, 8'hFF);
      wake_can();
      wr(ADDR_G_DATA, 8'h4A);
      cyc(3);
      chk({6'h00, halt_req, idle_req}, 8'h01);
      rd(ADDR_G_DATA, 8'h0A, 8'hFF);
      wake_can();
   endtask
   task automatic t_spi();
      wr(ADDR_M_CFG, 8'h0F);
      {spi_miso_o, spi_mosi_o, spi_sck_o, spi_ss_o} = 4'hF;
      spi_master = 1'b1;
      spi_enable = 1'b1;
      cyc(3);
      chk(m_oe & 8'h0F, 8'h0E);
      chk(m_out & 8'h0E, 8'h0E);
      spi_master = 1'b0;
      cyc(3);
      chk(m_oe & 8'h0F, 8'h01);
      chk(m_out & 8'h01, 8'h01);
      spi_enable = 1'b0;
      cyc(3);
      chk(m_oe & 8'h0F, 8'h0F);
      chk(m_out & 8'h0F, 8'h0A);
      wr(ADDR_M_CFG, 8'h0C);
   endtask
   task automatic t_wake();
      wr(ADDR_M_ALT, 8'h01);
      wr(ADDR_WAKE_EN, 8'h01);
      wr(ADDR_WAKE_PEND, 8'hFF);
      toggle(0);
      rd(ADDR_M_PIN, xv, 8'h01);
      toggle(0);
      chk({7'h00, multi_input_wakeup}, 8'h00);
      toggle(1);
      toggle(1);
      chk({7'h00, multi_input_wakeup}, 8'h01);
      wr(ADDR_M_ALT, 8'h00);
      wr(ADDR_WAKE_PEND, 8'hFF);
      chk({7'h00, multi_input_wakeup}, 8'h00);
      toggle(0);
      toggle(0);
      chk({7'h00, multi_input_wakeup}, 8'h01);
      rd(ADDR_WAKE_PEND, 8'h01, 8'hFF);
   endtask
   task automatic t_ext();
      // upper four pins taken as unbonded, so made outputs
      wr(ADDR_N_CFG, 8'hFD);
      wr(ADDR_N_ALT, 8'h01);
      slave_select_extension = 8'h01;
      cyc(3);
      chk(n_out & n_oe & 8'h01, 8'h01);
      slave_select_extension = 8'h00;
      cyc(3);
      chk({6'h00, n_oe[0], n_out[0]}, 8'h02);
   endtask
   task automatic t_can();
      {can_tx_0, can_tx_1} = 2'b11;
      wr(ADDR_CAN_CTL, 8'h01);
      cyc(3);
      chk({6'h00, can_transmit_oe_1, can_transmit_oe_0}, 8'h01);
      chk({7'h00, can_transmit_out_0}, 8'h01);
      wr(ADDR_CAN_CTL, 8'h02);
      can_tx_1 = 1'b0;
      cyc(3);
      chk({6'h00, can_transmit_oe_1, can_transmit_oe_0}, 8'h02);
      chk({7'h00, can_transmit_out_1}, 8'h00);
   endtask
   task automatic t_analog();
      i_in = 8'h3C;
      cyc(3);
      rd(ADDR_I_PIN, 8'h3C, 8'hFF);
      rd(8'h00, 8'h00, 8'hFF);
      wr(ADDR_D_DATA, 8'h5A);
      cyc(1);
      chk(d_out, 8'h5A);
      rd(ADDR_D_DATA, 8'h5A, 8'hFF);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------
   // main sequence and hang guard
   // ------
   initial begin
      rst = 1'b1;
      {bus_wr, bus_rd, xe, clock_in, spi_enable, spi_master, spi_miso_o,
       spi_mosi_o, spi_sck_o, spi_ss_o, can_tx_0, can_tx_1,
       can_rx_activity} = '0;
      {bus_addr, bus_wdata, lxv, xv, i_in, slave_select_extension} = '0;
      t_reset();
      t_modes();
      t_special();
      t_sleep();
      t_spi();
      t_wake();
      t_ext();
      t_can();
      t_analog();
      wrap_up();
   end
   initial begin
      #200000;
      error_cnt++;
      wrap_up();
   end
endmodule
`default_nettype wire
